// file: hw/psb_defines.svh
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH

// Port mode field encodings
`define PSB_MODE_LEGACY 2'h0
`define PSB_MODE_ADDRESSED 2'h1
// Increment mode value that turns the legacy port into the buffered port
`define PSB_INC_BUFFERED 2'h3
// Interrupt mode encodings for the buffered and addressed ports
`define PSB_IRQ_EVERY 2'h1
`define PSB_IRQ_FOURTH 2'h3
// Slot index that closes a group of four
`define PSB_LAST_SLOT 2'h3
// Status byte layout
`define PSB_STAT_SUMMARY 7
`define PSB_STAT_ERROR 6
`define PSB_STAT_PAD 2'h0
// Reset values of the slot flags and data bytes
`define PSB_EMPTY_RST 4'hf
`define PSB_FULL_RST 4'h0
`define PSB_BYTE_RST 8'h00
// Pin map value that keeps the port on the pins shared with the memory bus
`define PSB_PIN_DEFAULT 1'b1
// Synchroniser depth plus edge register, before strobes are believed
`define PSB_SETTLE_CYCLES 2'h3

`endif

// file: hw/psb_pkg.sv
package psb_pkg;

    // Master cycle sequencer, Gray coded along its only path
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SETUP = 2'h1,
        ST_STROBE = 2'h3,
        ST_HOLD = 2'h2
    } psb_mst_e;

    // Static configuration as software sets it
    typedef struct packed {
        logic module_enable;
        logic [1:0] port_mode_field;
        logic [1:0] increment_mode_field;
        logic [1:0] interrupt_mode_field;
        logic cs_active_high;
        logic rd_active_high;
        logic wr_active_high;
        logic pin_map_select;
    } psb_cfg_s;

    // One pin set as seen from the pads
    typedef struct packed {
        logic [7:0] data;
        logic read_strobe;
        logic write_strobe;
    } psb_pad_in_s;

    typedef struct packed {
        logic [7:0] data;
        logic data_oe;
        logic read_strobe;
        logic read_strobe_oe;
        logic write_strobe;
        logic write_strobe_oe;
    } psb_pad_out_s;

endpackage

// file: hw/psb_sync.sv
`timescale 1ns/1ns

// Two-flop synchroniser for a group of asynchronous host pins
module psb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // psb_sync

// file: hw/psb_top.sv
`timescale 1ns/1ns
`include "psb_defines.svh"

// Contract
// [RQ1] Pin map bit selects default or alternate pins
// [RQ2] Mode 00 with enable gives legacy port
// [RQ3] Host drives strobes asynchronously; device only responds
// [RQ4] Legacy write captures data into input slot zero
// [RQ5] Legacy write end sets interrupt and full
// [RQ6] Legacy read drives output slot zero
// [RQ7] Chip select and strobe polarity configurable
// [RQ8] Increment mode 11 gives four-slot buffered port
// [RQ9] Buffered reads walk output slots zero to three
// [RQ10] Empty flag per slot, plus all-empty summary
// [RQ11] Reading empty slot sets underflow
// [RQ12] Buffered writes walk input slots zero to three
// [RQ13] Full flag per slot, software read clears
// [RQ14] Writing full slot sets overflow, byte lost
// [RQ15] Interrupt every strobe or every slot three
// [RQ16] Mode 01 addresses slots by two pins
// [RQ17] Addressed read drives chosen slot, sets empty
// [RQ18] Addressed write stores chosen slot, sets full
// [RQ19] Addressed write to full slot discarded, error
// [RQ20] Master needs enable and mode 1x
// [RQ21] Master drives data, address, selects, strobes
// [RQ22] Overflow and underflow stay until software clears
// [RQ23] Host pins synchronised, strobe edges act once
module psb_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire psb_pkg::psb_cfg_s cfg,
    // Default and alternate pin sets
    input wire psb_pkg::psb_pad_in_s pad_dflt_i,
    input wire psb_pkg::psb_pad_in_s pad_alt_i,
    output psb_pkg::psb_pad_out_s pad_dflt_o,
    output psb_pkg::psb_pad_out_s pad_alt_o,
    // Slave chip select and slot address pins
    input wire logic chip_select_i,
    input wire logic [1:0] slave_buffer_address_i,
    // Master address and chip select pins
    output logic [15:0] master_addr_o,
    output logic [1:0] master_cs_o,
    // Software access to output slots
    input wire logic sw_out_wr,
    input wire logic [1:0] sw_out_idx,
    input wire logic [7:0] sw_out_data,
    // Software access to input slots
    input wire logic sw_in_rd,
    input wire logic [1:0] sw_in_idx,
    output logic [7:0] sw_in_data,
    // Software flag clears
    input wire logic sw_clr_ovf,
    input wire logic sw_clr_unf,
    input wire logic sw_clr_irq,
    // Software master requests
    input wire logic mst_rd_req,
    input wire logic mst_wr_req,
    input wire logic [15:0] mst_addr,
    input wire logic [1:0] mst_cs,
    input wire logic [7:0] mst_wdata,
    output logic mst_busy,
    output logic [7:0] mst_rdata,
    // Status
    output logic [7:0] output_status,
    output logic [7:0] input_status,
    output logic port_interrupt_flag
);

    logic legacy, buffered, addressed, master, slave;
    psb_pkg::psb_pad_in_s pad_in;
    logic [12:0] sync_d, sync_q;
    logic [7:0] sdata;
    logic [1:0] saddr;
    logic cs_act, rd_act, wr_act, rd_on, wr_on, rd_prev, wr_prev;
    logic rd_end, wr_end;
    logic [1:0] settle;
    logic [7:0] in_buf [4];
    logic [7:0] out_buf [4];
    logic [3:0] in_full, out_empty;
    logic ovf, unf;
    logic [1:0] rd_ptr, wr_ptr, rd_slot, cur_rd_slot, wr_slot;
    logic [1:0] wr_hold_addr;
    logic [7:0] wr_hold_data;
    logic [7:0] data_q;
    logic data_oe_q, rd_lvl, wr_lvl;
    psb_pkg::psb_mst_e state;
    logic m_write, mst_start;
    logic all_full, all_empty, irq_event;

    // Mode decode; master ignores the increment field
    assign legacy = cfg.module_enable && cfg.port_mode_field == `PSB_MODE_LEGACY
        && cfg.increment_mode_field != `PSB_INC_BUFFERED; // RQ2
    assign buffered = cfg.module_enable && cfg.port_mode_field == `PSB_MODE_LEGACY
        && cfg.increment_mode_field == `PSB_INC_BUFFERED; // RQ8
    assign addressed = cfg.module_enable
        && cfg.port_mode_field == `PSB_MODE_ADDRESSED; // RQ16
    assign master = cfg.module_enable && cfg.port_mode_field[1]; // RQ20
    assign slave = legacy || buffered || addressed;

    // Pick the pin set the strobes and data arrive on
    assign pad_in = (cfg.pin_map_select == `PSB_PIN_DEFAULT) ? pad_dflt_i : pad_alt_i; // RQ1

    // Host pins arrive with no relation to clk; data rides with the strobes
    assign sync_d = {chip_select_i, pad_in.read_strobe, pad_in.write_strobe,
        slave_buffer_address_i, pad_in.data}; // RQ3

    psb_sync #(
        .W(13)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(sync_d),
        .q(sync_q)
    ); // RQ23

    assign sdata = sync_q[7:0];
    assign saddr = sync_q[9:8];

    // Polarity is applied after the synchroniser, so one flop chain serves both
    assign cs_act = ~(sync_q[12] ^ cfg.cs_active_high); // RQ7
    assign rd_act = ~(sync_q[11] ^ cfg.rd_active_high); // RQ7
    assign wr_act = ~(sync_q[10] ^ cfg.wr_active_high); // RQ7

    // Ignore strobes until the chain holds real pin values, else an
    // active-low setup would see a phantom strobe out of reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settle <= 2'h0;
        end else if (settle != `PSB_SETTLE_CYCLES) begin
            settle <= settle + 2'h1;
        end
    end

    assign rd_on = slave && settle == `PSB_SETTLE_CYCLES && cs_act && rd_act;
    assign wr_on = slave && settle == `PSB_SETTLE_CYCLES && cs_act && wr_act;

    // Edge detect: each strobe yields one end pulse, in the cycle it drops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end else begin
            rd_prev <= rd_on;
            wr_prev <= wr_on;
        end
    end

    assign rd_end = !rd_on && rd_prev; // RQ23
    assign wr_end = !wr_on && wr_prev; // RQ23

    // Slot choice: pins in addressed mode, pointer when buffered, else zero
    assign cur_rd_slot = addressed ? saddr : (buffered ? rd_ptr : 2'h0); // RQ9 RQ17
    assign wr_slot = addressed ? wr_hold_addr : (buffered ? wr_ptr : 2'h0); // RQ12 RQ18

    // Hold what the host presented while the strobe was active;
    // the commit happens at the end, when address may already move
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_hold_data <= `PSB_BYTE_RST;
            wr_hold_addr <= 2'h0;
            rd_slot <= 2'h0;
        end else begin
            if (wr_on) begin
                wr_hold_data <= sdata;
                wr_hold_addr <= saddr;
            end
            if (rd_on) begin
                rd_slot <= cur_rd_slot;
            end
        end
    end

    // Sequential pointers; cleared outside the buffered port
    always_ff @(posedge clk) begin
        if (!rst_n || !buffered) begin
            rd_ptr <= 2'h0;
            wr_ptr <= 2'h0;
        end else begin
            if (rd_end) begin
                rd_ptr <= rd_ptr + 2'h1; // RQ9
            end
            if (wr_end) begin
                wr_ptr <= wr_ptr + 2'h1; // RQ12
            end
        end
    end

    // Input slots: legacy follows the bus during the strobe, others
    // commit at strobe end and refuse a slot that still holds data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                in_buf[i] <= `PSB_BYTE_RST;
            end
        end else if (legacy && wr_on) begin
            in_buf[0] <= sdata; // RQ4
        end else if (wr_end && !legacy && !in_full[wr_slot]) begin
            in_buf[wr_slot] <= wr_hold_data; // RQ12 RQ14 RQ18 RQ19
        end
    end

    // Full flags; a host write beats a software read of the same slot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_full <= `PSB_FULL_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_end && wr_slot == 2'(i)) begin
                    in_full[i] <= 1'b1; // RQ5 RQ13 RQ18
                end else if (sw_in_rd && sw_in_idx == 2'(i)) begin
                    in_full[i] <= 1'b0; // RQ13
                end
            end
        end
    end

    // Output slots are loaded by software only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                out_buf[i] <= `PSB_BYTE_RST;
            end
        end else if (sw_out_wr) begin
            out_buf[sw_out_idx] <= sw_out_data;
        end
    end

    // Empty flags; a host read beats a software load of the same slot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_empty <= `PSB_EMPTY_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (rd_end && rd_slot == 2'(i)) begin
                    out_empty[i] <= 1'b1; // RQ10 RQ17
                end else if (sw_out_wr && sw_out_idx == 2'(i)) begin
                    out_empty[i] <= 1'b0; // RQ10
                end
            end
        end
    end

    // Error flags hold until software clears them; a new error wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovf <= 1'b0;
            unf <= 1'b0;
        end else begin
            if (wr_end && !legacy && in_full[wr_slot]) begin
                ovf <= 1'b1; // RQ14 RQ19
            end else if (sw_clr_ovf) begin
                ovf <= 1'b0; // RQ22
            end
            if (rd_end && !legacy && out_empty[rd_slot]) begin
                unf <= 1'b1; // RQ11 RQ17
            end else if (sw_clr_unf) begin
                unf <= 1'b0; // RQ22
            end
        end
    end

    // Interrupt source per mode
    always_comb begin
        irq_event = 1'b0;
        if (legacy) begin
            irq_event = wr_end; // RQ5
        end else if (cfg.interrupt_mode_field == `PSB_IRQ_EVERY) begin
            irq_event = rd_end || wr_end; // RQ15
        end else if (cfg.interrupt_mode_field == `PSB_IRQ_FOURTH) begin
            irq_event = (rd_end && rd_slot == `PSB_LAST_SLOT)
                || (wr_end && wr_slot == `PSB_LAST_SLOT); // RQ15
        end
    end

    // Sticky interrupt flag; the event beats the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_interrupt_flag <= 1'b0;
        end else if (irq_event && slave) begin
            port_interrupt_flag <= 1'b1;
        end else if (sw_clr_irq) begin
            port_interrupt_flag <= 1'b0;
        end
    end

    // Master sequencer: one clock per phase, write wins a tie
    assign mst_start = master && state == psb_pkg::ST_IDLE && (mst_rd_req || mst_wr_req);
    assign mst_busy = state != psb_pkg::ST_IDLE;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= psb_pkg::ST_IDLE;
        end else begin
            unique case (state)
                psb_pkg::ST_IDLE: begin
                    if (mst_start) begin
                        state <= psb_pkg::ST_SETUP; // RQ20
                    end
                end
                psb_pkg::ST_SETUP: begin
                    state <= psb_pkg::ST_STROBE;
                end
                psb_pkg::ST_STROBE: begin
                    state <= psb_pkg::ST_HOLD;
                end
                psb_pkg::ST_HOLD: begin
                    state <= psb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Master address, selects and strobe levels, polarity applied
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            m_write <= 1'b0;
            master_addr_o <= 16'h0000;
            master_cs_o <= 2'h0;
            rd_lvl <= 1'b0;
            wr_lvl <= 1'b0;
            mst_rdata <= `PSB_BYTE_RST;
        end else begin
            if (mst_start) begin
                m_write <= mst_wr_req;
                master_addr_o <= mst_addr; // RQ21
            end
            master_cs_o <= ({2{mst_busy || mst_start}} & mst_cs)
                ^ {2{~cfg.cs_active_high}}; // RQ21
            rd_lvl <= ~((state == psb_pkg::ST_SETUP && !m_write) ^ cfg.rd_active_high);
            wr_lvl <= ~((state == psb_pkg::ST_SETUP && m_write) ^ cfg.wr_active_high);
            if (state == psb_pkg::ST_STROBE && !m_write) begin
                mst_rdata <= pad_in.data; // RQ21
            end
        end
    end

    // Data pins: slave read drives the chosen slot, master write its byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= `PSB_BYTE_RST;
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= rd_on || (mst_busy && m_write);
            if (rd_on) begin
                data_q <= out_buf[cur_rd_slot]; // RQ6 RQ9 RQ17
            end else if (mst_start && mst_wr_req) begin
                data_q <= mst_wdata; // RQ21
            end
        end
    end

    // Route drivers to the selected pin set only
    always_comb begin
        pad_dflt_o = '0;
        pad_alt_o = '0;
        if (cfg.pin_map_select == `PSB_PIN_DEFAULT) begin
            pad_dflt_o = {data_q, data_oe_q, rd_lvl, master, wr_lvl, master}; // RQ1
        end else begin
            pad_alt_o = {data_q, data_oe_q, rd_lvl, master, wr_lvl, master}; // RQ1
        end
    end

    // Summaries; only the full summary treats legacy as a single slot
    assign all_full = legacy ? in_full[0] : &in_full; // RQ13
    assign all_empty = &out_empty; // RQ10
    assign output_status = {all_empty, unf, `PSB_STAT_PAD, out_empty};
    assign input_status = {all_full, ovf, `PSB_STAT_PAD, in_full};

    // Software sees input slots from flops; read port is a plain mux
    assign sw_in_data = in_buf[sw_in_idx];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    legacy_capture_a: assert property (legacy && wr_on |=> in_buf[0] == $past(sdata)) // RQ4
        else $error("legacy write not captured");
    legacy_flags_a: assert property (legacy && wr_end |=> port_interrupt_flag && in_full[0]) // RQ5
        else $error("legacy write end flags missing");
    legacy_drive_a: assert property (legacy && rd_on // RQ6
        |=> data_oe_q && data_q == $past(out_buf[0]))
        else $error("legacy read not driven");
    rd_ptr_step_a: assert property (buffered && rd_end |=> rd_ptr == $past(rd_ptr) + 2'h1) // RQ9
        else $error("read pointer did not step");
    wr_ptr_step_a: assert property (buffered && wr_end |=> wr_ptr == $past(wr_ptr) + 2'h1) // RQ12
        else $error("write pointer did not step");
    empty_on_read_a: assert property (rd_end |=> out_empty[$past(rd_slot)]) // RQ10
        else $error("slot not empty after read");
    underflow_set_a: assert property (rd_end && !legacy && out_empty[rd_slot] |=> unf) // RQ11
        else $error("underflow missed");
    overflow_keep_a: assert property (wr_end && !legacy && in_full[wr_slot] // RQ14
        |=> ovf && in_buf[$past(wr_slot)] == $past(in_buf[wr_slot]))
        else $error("overflow byte not dropped");
    addr_write_a: assert property (addressed && wr_end && !in_full[wr_hold_addr] // RQ18
        |=> in_full[$past(wr_hold_addr)] && in_buf[$past(wr_hold_addr)] == $past(wr_hold_data))
        else $error("addressed write lost");
    error_sticky_a: assert property (ovf && !sw_clr_ovf |=> ovf) // RQ22
        else $error("overflow dropped by itself");
    fourth_irq_a: assert property (buffered && cfg.interrupt_mode_field == `PSB_IRQ_FOURTH // RQ15
        && wr_end && wr_slot != `PSB_LAST_SLOT && !rd_end && !port_interrupt_flag
        |=> !port_interrupt_flag)
        else $error("interrupt before slot three");
    master_seq_a: assert property (mst_start |=> state == psb_pkg::ST_SETUP // RQ20
        ##1 state == psb_pkg::ST_STROBE ##1 state == psb_pkg::ST_HOLD
        ##1 state == psb_pkg::ST_IDLE)
        else $error("master sequence broken");
    single_end_a: assert property (buffered && !rd_end |=> rd_ptr == $past(rd_ptr)) // RQ23
        else $error("read strobe ended twice");

    buffered_wrap_c: cover property (buffered && wr_end && wr_slot == `PSB_LAST_SLOT);
    addr_underflow_c: cover property (addressed && rd_end && out_empty[rd_slot]);
    master_read_c: cover property (mst_start && mst_rd_req);

endmodule // psb_top

// file: verif/psb_host_model.sv
`timescale 1ns/1ns

// Host on the far side: moves its pins just after a falling edge, holds each strobe 5 clocks
module psb_host_model (
    // Clock and configuration
    input wire logic clk,
    input wire psb_pkg::psb_cfg_s cfg,
    // Device pad outputs
    input wire psb_pkg::psb_pad_out_s pad_dflt_o,
    input wire psb_pkg::psb_pad_out_s pad_alt_o,
    // Host pins
    output psb_pkg::psb_pad_in_s pad_dflt_i,
    output psb_pkg::psb_pad_in_s pad_alt_i,
    output logic chip_select_i,
    output logic [1:0] slave_buffer_address_i
);
    logic cs_on = 1'b0;
    logic rd_on = 1'b0;
    logic wr_on = 1'b0;
    logic drv = 1'b0;
    logic [7:0] dq = 8'h00;
    psb_pkg::psb_pad_in_s act;
    psb_pkg::psb_pad_in_s idle;

    initial slave_buffer_address_i = 2'h0;

    // Released data shows the inverse of the last byte, so a stale value never passes
    always_comb begin
        act.data = drv ? dq : ~dq;
        act.read_strobe = rd_on ~^ cfg.rd_active_high;
        act.write_strobe = wr_on ~^ cfg.wr_active_high;
        idle.data = ~dq;
        idle.read_strobe = ~cfg.rd_active_high;
        idle.write_strobe = ~cfg.wr_active_high;
    end

    // Only the pin set chosen by the map bit carries traffic
    assign pad_dflt_i = cfg.pin_map_select ? act : idle;
    assign pad_alt_i = cfg.pin_map_select ? idle : act;
    assign chip_select_i = cs_on ~^ cfg.cs_active_high;

    // One access; the read byte only counts while the device enables its drivers
    task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        psb_pkg::psb_pad_out_s po;
        @(negedge clk);
        slave_buffer_address_i = a;
        dq = d;
        drv = wr;
        cs_on = 1'b1;
        rd_on = ~wr;
        wr_on = wr;
        repeat (5) @(posedge clk);
        @(negedge clk);
        po = cfg.pin_map_select ? pad_dflt_o : pad_alt_o;
        q = po.data_oe ? po.data : 8'hxx;
        cs_on = 1'b0;
        rd_on = 1'b0;
        wr_on = 1'b0;
        drv = 1'b0;
        repeat (5) @(negedge clk);
    endtask
endmodule // psb_host_model

// file: verif/psb_top_tb.sv
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); err_count++; end end

module psb_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    psb_pkg::psb_cfg_s cfg;
    psb_pkg::psb_pad_in_s pad_dflt_i, pad_alt_i;
    psb_pkg::psb_pad_out_s pad_dflt_o, pad_alt_o;
    logic chip_select_i, sw_out_wr, sw_in_rd, sw_clr_ovf, sw_clr_unf, sw_clr_irq;
    logic mst_rd_req, mst_wr_req, mst_busy, port_interrupt_flag;
    logic [1:0] slave_buffer_address_i, master_cs_o, sw_out_idx, sw_in_idx, mst_cs, a;
    logic [15:0] master_addr_o, mst_addr;
    logic [7:0] sw_out_data, sw_in_data, mst_wdata, mst_rdata, output_status, input_status;
    logic [7:0] q, d, ob[4], ib[4];
    integer seed = 32'h660d;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int i;

    psb_top psb_top_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .pad_dflt_i(pad_dflt_i),
        .pad_alt_i(pad_alt_i), .pad_dflt_o(pad_dflt_o), .pad_alt_o(pad_alt_o),
        .chip_select_i(chip_select_i), .slave_buffer_address_i(slave_buffer_address_i),
        .master_addr_o(master_addr_o), .master_cs_o(master_cs_o), .sw_out_wr(sw_out_wr),
        .sw_out_idx(sw_out_idx), .sw_out_data(sw_out_data), .sw_in_rd(sw_in_rd),
        .sw_in_idx(sw_in_idx), .sw_in_data(sw_in_data), .sw_clr_ovf(sw_clr_ovf),
        .sw_clr_unf(sw_clr_unf), .sw_clr_irq(sw_clr_irq), .mst_rd_req(mst_rd_req),
        .mst_wr_req(mst_wr_req), .mst_addr(mst_addr), .mst_cs(mst_cs), .mst_wdata(mst_wdata),
        .mst_busy(mst_busy), .mst_rdata(mst_rdata), .output_status(output_status),
        .input_status(input_status), .port_interrupt_flag(port_interrupt_flag));

    psb_host_model psb_host_model_i (.clk(clk), .cfg(cfg), .pad_dflt_o(pad_dflt_o),
        .pad_alt_o(pad_alt_o), .pad_dflt_i(pad_dflt_i), .pad_alt_i(pad_alt_i),
        .chip_select_i(chip_select_i), .slave_buffer_address_i(slave_buffer_address_i));

    // Clock, 100 ns period
    initial forever #50 clk = ~clk;

    // A hang is cut short well past the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Status byte as it should read: summary, sticky error, two zeros, slot flags
    function automatic logic [7:0] stat(input logic e, input logic [3:0] fl);
        return {&fl, e, 2'h0, fl};
    endfunction

    task automatic sw_load(input logic [1:0] k, input logic [7:0] v);
        @(negedge clk);
        sw_out_wr = 1'b1;
        sw_out_idx = k;
        sw_out_data = v;
        @(negedge clk);
        sw_out_wr = 1'b0;
    endtask

    task automatic sw_take(input logic [1:0] k, output logic [7:0] v);
        @(negedge clk);
        sw_in_idx = k;
        #1 v = sw_in_data;
        sw_in_rd = 1'b1;
        @(negedge clk);
        sw_in_rd = 1'b0;
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    initial begin
        cfg = '0;
        cfg.module_enable = 1'b1;
        {sw_out_wr, sw_in_rd, sw_clr_ovf, sw_clr_unf, sw_clr_irq} = 5'h00;
        {sw_out_idx, sw_in_idx, sw_out_data} = 12'h000;
        {mst_rd_req, mst_wr_req, mst_addr, mst_cs, mst_wdata} = 28'h000_0000;
        // Legacy port: alternate pins active low, then default pins active high.
        // Polarity only changes under reset, where a flipped level cannot look like a strobe.
        for (i = 0; i < 2; i++) begin
            {cfg.pin_map_select, cfg.cs_active_high} = {i[0], i[0]};
            {cfg.rd_active_high, cfg.wr_active_high} = {i[0], i[0]};
            rst_n = 1'b0;
            repeat (5) @(negedge clk);
            rst_n = 1'b1;
            @(negedge clk);
            `CHK("out_status", stat(1'b0, 4'hf), output_status)
            `CHK("in_status", stat(1'b0, 4'h0), input_status)
            repeat (8) @(negedge clk);
            ob[0] = 8'($random(seed));
            sw_load(2'h0, ob[0]);
            psb_host_model_i.access(1'b0, 2'h0, 8'h00, q);
            `CHK("legacy_rd", ob[0], q)
            ib[0] = 8'($random(seed));
            psb_host_model_i.access(1'b1, 2'h0, ib[0], q);
            `CHK("legacy_full", 1'b1, input_status[0])
            `CHK("legacy_irq", 1'b1, port_interrupt_flag)
            sw_take(2'h0, q);
            `CHK("legacy_wr", ib[0], q)
            pulse(sw_clr_irq);
        end
        // Buffered port, interrupt on slot three only, then on every strobe
        cfg.increment_mode_field = 2'h3;
        cfg.interrupt_mode_field = 2'h3;
        for (i = 0; i < 4; i++) begin
            ob[i] = 8'($random(seed));
            sw_load(i[1:0], ob[i]);
        end
        @(negedge clk);
        `CHK("loaded", stat(1'b0, 4'h0), output_status)
        for (i = 0; i < 5; i++) begin
            psb_host_model_i.access(1'b0, 2'h0, 8'h00, q);
            if (i < 4) `CHK("buf_rd", ob[i], q)
            `CHK("rd_irq", (i > 2), port_interrupt_flag)
        end
        `CHK("underflow", stat(1'b1, 4'hf), output_status)
        pulse(sw_clr_unf);
        pulse(sw_clr_irq);
        `CHK("unf_clear", stat(1'b0, 4'hf), output_status)
        for (i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            if (i < 4) ib[i] = d;
            psb_host_model_i.access(1'b1, 2'h0, d, q);
            `CHK("buf_full", stat((i > 3), 4'((1 << (i + 1)) - 1)), input_status)
            `CHK("wr_irq", (i > 2), port_interrupt_flag)
        end
        for (i = 0; i < 4; i++) begin
            sw_take(i[1:0], q);
            `CHK("buf_data", ib[i], q)
        end
        @(negedge clk);
        `CHK("drained", stat(1'b1, 4'h0), input_status)
        pulse(sw_clr_ovf);
        pulse(sw_clr_irq);
        cfg.interrupt_mode_field = 2'h1;
        psb_host_model_i.access(1'b1, 2'h0, 8'h5a, q);
        `CHK("every_irq", 1'b1, port_interrupt_flag)
        pulse(sw_clr_irq);
        sw_take(2'h1, q);
        // Addressed port, slots out of order, the last pair hits a used slot
        cfg.port_mode_field = 2'h1;
        cfg.increment_mode_field = 2'h0;
        cfg.interrupt_mode_field = 2'h0;
        for (i = 0; i < 4; i++) begin
            ob[i] = 8'($random(seed));
            sw_load(i[1:0], ob[i]);
        end
        for (i = 0; i < 5; i++) begin
            a = i[1:0] ^ 2'h1;
            psb_host_model_i.access(1'b0, a, 8'h00, q);
            `CHK("adr_rd", ob[a], q)
            d = 8'($random(seed));
            if (i < 4) ib[a] = d;
            psb_host_model_i.access(1'b1, a, d, q);
        end
        `CHK("adr_out", stat(1'b1, 4'hf), output_status)
        `CHK("adr_in", stat(1'b1, 4'hf), input_status)
        for (i = 0; i < 4; i++) begin
            sw_take(i[1:0], q);
            `CHK("adr_data", ib[i], q)
        end
        // Master write cycle, then a read cycle
        pulse(sw_clr_ovf);
        pulse(sw_clr_unf);
        cfg.port_mode_field = 2'h2;
        @(negedge clk);
        mst_wr_req = 1'b1;
        mst_addr = 16'($random(seed));
        mst_cs = 2'h1;
        mst_wdata = 8'($random(seed));
        @(negedge clk);
        mst_wr_req = 1'b0;
        `CHK("mst_busy", 1'b1, mst_busy)
        @(negedge clk);
        `CHK("mst_addr", {mst_cs, mst_addr}, {master_cs_o, master_addr_o})
        `CHK("mst_data", {1'b1, mst_wdata}, {pad_dflt_o.data_oe, pad_dflt_o.data})
        repeat (2) @(negedge clk);
        `CHK("mst_idle", 1'b0, mst_busy)
        mst_rd_req = 1'b1;
        @(negedge clk);
        mst_rd_req = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("mst_rd", ~d, mst_rdata)
        test_done();
    end
endmodule // psb_top_tb
